//--- design/pslv_pkg.sv
package pslv_pkg;

    // register byte offsets, one aligned word each
    localparam logic [7:0] OFF_PD_PINS   = 8'h00;
    localparam logic [7:0] OFF_PD_LATCH  = 8'h04;
    localparam logic [7:0] OFF_PD_DIR    = 8'h08;
    localparam logic [7:0] OFF_PE_PINS   = 8'h0c;
    localparam logic [7:0] OFF_PE_LATCH  = 8'h10;
    localparam logic [7:0] OFF_PE_CTL    = 8'h14;
    localparam logic [7:0] OFF_FLAGS     = 8'h18;
    localparam logic [7:0] OFF_FLAGS_CLR = 8'h1c;
    localparam logic [7:0] OFF_ENABLES   = 8'h20;
    localparam logic [7:0] OFF_PRIORITY  = 8'h24;
    localparam logic [7:0] OFF_ANALOG    = 8'h28;

    // port e control/direction fields
    localparam int CTL_IN_FULL  = 7;
    localparam int CTL_OUT_FULL = 6;
    localparam int CTL_IN_OVF   = 5;
    localparam int CTL_ENABLE   = 4;

    // event flag and its enable sit at bit 7 of flags/enables
    localparam int FLAG_EVENT   = 7;

    // analog select bits 7:5 cover strobe pins 2:0
    localparam int ANA_STROBE_LSB = 5;

    // strobe pin positions on port e
    localparam int PIN_READ   = 0;
    localparam int PIN_WRITE  = 1;
    localparam int PIN_SELECT = 2;

    localparam logic [7:0] RST_PD_DIR  = 8'hff;
    localparam logic [2:0] RST_PE_DIR  = 3'h7;
    localparam logic [7:0] RST_ANALOG  = 8'hff;
    localparam logic [7:0] RST_ZERO8   = 8'h00;
    localparam logic [2:0] RST_ZERO3   = 3'h0;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage : pslv_pkg

//--- design/pslv_sync.sv
`timescale 1ns/1ps
module pslv_sync
    import pslv_pkg::*;
#(
    parameter int WIDTH = 11
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // two flops; meta_reg feeds only sync_out, reset to idle-high
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= '1;
            sync_out <= '1;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule : pslv_sync

//--- design/pslv_top.sv
// Operation
// RL1: port d acts as slave port when enabled and no multi-output pwm runs
// RL2: slave port control and status sit in top four control bits
// RL3: external master reads and writes without a clock; strobes get sampled
// RL4: external side sees the port d latch as one 8-bit latch
// RL5: in slave mode port e pins 0,1,2 are read, write, select strobes
// RL6: software sets strobe pins as inputs and clears their analog bits
// RL7: write runs while select and write are low, ends when either rises
// RL8: write end sets event flag and input full flag
// RL9: read start drives latch onto port d and clears output full
// RL10: software write during read drives at once, output full stays clear
// RL11: read end floats port d and sets the event flag
// RL12: software waits for event flag then polls the full flags
// RL13: software read of port d clears input full; write onto full overflows
// RL14: software write outside read sets output full until master reads
`timescale 1ns/1ps
module pslv_top
    import pslv_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic [7:0]        port_d_in,
    output logic      [7:0]        port_d_out,
    output logic      [7:0]        port_d_oe,
    input  wire logic [2:0]        port_e_in,
    output logic      [2:0]        port_e_out,
    output logic      [2:0]        port_e_oe,
    input  wire logic              pwm_multi_output,
    output logic                   irq
);

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == OFF_PD_PINS)   || (a == OFF_PD_LATCH)  ||
                    (a == OFF_PD_DIR)    || (a == OFF_PE_PINS)   ||
                    (a == OFF_PE_LATCH)  || (a == OFF_PE_CTL)    ||
                    (a == OFF_FLAGS)     || (a == OFF_FLAGS_CLR) ||
                    (a == OFF_ENABLES)   || (a == OFF_PRIORITY)  ||
                    (a == OFF_ANALOG);
    endfunction : is_mapped

    logic [7:0]  aw_addr_reg;
    logic        aw_held_reg;
    logic [7:0]  w_data_reg;
    logic        w_lane0_reg;
    logic        w_held_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;

    logic [7:0]  latch_reg;
    logic [7:0]  pd_dir_reg;
    logic [2:0]  pe_latch_reg;
    logic [2:0]  pe_dir_reg;
    logic        enable_reg;
    logic        in_full_reg;
    logic        out_full_reg;
    logic        in_ovf_reg;
    logic        event_reg;
    logic [7:0]  enables_reg;
    logic [7:0]  priority_reg;
    logic [7:0]  analog_reg;
    logic [7:0]  in_buf_reg;
    logic        wr_act_reg;
    logic        rd_act_reg;

    logic [10:0] pins_sync;
    logic [7:0]  pd_sync;
    logic [2:0]  pe_eff;
    logic        slave_on;
    logic        wr_act;
    logic        rd_act;
    logic        wr_end;
    logic        rd_start;
    logic        rd_end;
    logic        bus_wr;
    logic        sw_wr;
    logic        ar_take;
    logic        sw_pd_read;
    logic        sw_pd_write;
    logic [31:0] rd_mux;
    logic [7:0]  ctl_view;

    // strobes and data cross in from the pins through two flops
    pslv_sync #(
        .WIDTH (11)
    ) i_pslv_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in ({port_e_in, port_d_in}),
        .sync_out (pins_sync)
    );

    assign pd_sync = pins_sync[7:0];
    // analog-selected pins read high so a strobe stays idle
    assign pe_eff  = pins_sync[10:8] | analog_reg[7:ANA_STROBE_LSB];

    assign slave_on = enable_reg && !pwm_multi_output; // RL1
    assign wr_act   = slave_on && !pe_eff[PIN_SELECT]
                      && !pe_eff[PIN_WRITE]; // RL5 RL7
    assign rd_act   = slave_on && !pe_eff[PIN_SELECT]
                      && !pe_eff[PIN_READ]; // RL5
    assign wr_end   = wr_act_reg && !wr_act; // RL7
    assign rd_start = rd_act && !rd_act_reg;
    assign rd_end   = rd_act_reg && !rd_act;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_act_reg <= 1'b0;
            rd_act_reg <= 1'b0;
        end else begin
            wr_act_reg <= wr_act; // RL3
            rd_act_reg <= rd_act; // RL3
        end
    end

    // capture the master's byte on every sampled write cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in_buf_reg <= RST_ZERO8;
        end else if (wr_act) begin
            in_buf_reg <= pd_sync; // RL4
        end
    end

    // axi write channel
    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready  = !w_held_reg && !bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign bus_wr        = aw_held_reg && w_held_reg && !bvalid_reg;
    assign sw_wr         = bus_wr && w_lane0_reg && is_mapped(aw_addr_reg);
    assign sw_pd_write   = sw_wr && ((aw_addr_reg == OFF_PD_PINS)
                                  || (aw_addr_reg == OFF_PD_LATCH));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= RST_ZERO8;
            w_held_reg  <= 1'b0;
            w_data_reg  <= RST_ZERO8;
            w_lane0_reg <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr[7:0];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg  <= 1'b1;
                w_data_reg  <= s_axi_wdata[7:0];
                w_lane0_reg <= s_axi_wstrb[0];
            end
            if (bus_wr) begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= is_mapped(aw_addr_reg) ? RESP_OKAY
                                                      : RESP_DECERR;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg  <= 1'b0;
            end
        end
    end

    // axi read channel
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
    assign ar_take       = s_axi_arvalid && !rvalid_reg;
    assign sw_pd_read    = ar_take && (s_axi_araddr[7:0] == OFF_PD_PINS);

    assign ctl_view = {in_full_reg, out_full_reg, in_ovf_reg, enable_reg,
                       1'b0, pe_dir_reg}; // RL2

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (s_axi_araddr[7:0])
            OFF_PD_PINS:  rd_mux[7:0] = slave_on ? in_buf_reg : pd_sync;
            OFF_PD_LATCH: rd_mux[7:0] = latch_reg;
            OFF_PD_DIR:   rd_mux[7:0] = pd_dir_reg;
            OFF_PE_PINS:  rd_mux[2:0] = pe_eff;
            OFF_PE_LATCH: rd_mux[2:0] = pe_latch_reg;
            OFF_PE_CTL:   rd_mux[7:0] = ctl_view;
            OFF_FLAGS:    rd_mux[FLAG_EVENT] = event_reg;
            OFF_ENABLES:  rd_mux[7:0] = enables_reg;
            OFF_PRIORITY: rd_mux[7:0] = priority_reg;
            OFF_ANALOG:   rd_mux[7:0] = analog_reg;
            default:      rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_mux;
            rresp_reg  <= is_mapped(s_axi_araddr[7:0]) ? RESP_OKAY
                                                       : RESP_DECERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // plain configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            latch_reg    <= RST_ZERO8;
            pd_dir_reg   <= RST_PD_DIR;
            pe_latch_reg <= RST_ZERO3;
            pe_dir_reg   <= RST_PE_DIR;
            enable_reg   <= 1'b0;
            enables_reg  <= RST_ZERO8;
            priority_reg <= RST_ZERO8;
            analog_reg   <= RST_ANALOG;
        end else if (sw_wr) begin
            unique case (aw_addr_reg)
                OFF_PD_PINS:  latch_reg <= w_data_reg; // RL10
                OFF_PD_LATCH: latch_reg <= w_data_reg; // RL10
                OFF_PD_DIR:   pd_dir_reg <= w_data_reg;
                OFF_PE_LATCH: pe_latch_reg <= w_data_reg[2:0];
                OFF_PE_CTL: begin
                    enable_reg <= w_data_reg[CTL_ENABLE]; // RL2
                    pe_dir_reg <= w_data_reg[2:0]; // RL6
                end
                OFF_ENABLES:  enables_reg <= w_data_reg;
                OFF_PRIORITY: priority_reg <= w_data_reg;
                OFF_ANALOG:   analog_reg <= w_data_reg; // RL6
                default:      latch_reg <= latch_reg;
            endcase
        end
    end

    // handshake flags; a hardware set always beats a software clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in_full_reg <= 1'b0;
        end else if (wr_end) begin
            in_full_reg <= 1'b1; // RL8
        end else if (sw_pd_read) begin
            in_full_reg <= 1'b0; // RL13
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in_ovf_reg <= 1'b0;
        end else if (wr_end && in_full_reg && !sw_pd_read) begin
            in_ovf_reg <= 1'b1; // RL13
        end else if (sw_wr && (aw_addr_reg == OFF_PE_CTL)
                     && !w_data_reg[CTL_IN_OVF]) begin
            in_ovf_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_full_reg <= 1'b0;
        end else if (rd_act) begin
            out_full_reg <= 1'b0; // RL9 RL10
        end else if (sw_pd_write) begin
            out_full_reg <= 1'b1; // RL14
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            event_reg <= 1'b0;
        end else if (wr_end || rd_end) begin
            event_reg <= 1'b1; // RL8 RL11
        end else if (sw_wr && (aw_addr_reg == OFF_FLAGS_CLR)
                     && w_data_reg[FLAG_EVENT]) begin
            event_reg <= 1'b0; // RL12
        end
    end

    assign irq = event_reg && enables_reg[FLAG_EVENT];

    // pin drivers; latch goes straight out so new data shows at once
    assign port_d_out = latch_reg; // RL4 RL10
    assign port_d_oe  = slave_on ? {8{rd_act_reg}} : ~pd_dir_reg; // RL9 RL11
    assign port_e_out = pe_latch_reg;
    assign port_e_oe  = slave_on ? 3'h0 : ~pe_dir_reg; // RL5

    a_mode_gate: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !slave_on |=> !wr_act_reg && !rd_act_reg
    ) else $error("slave cycle tracked while mode is off"); // RL1

    a_write_end: assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_end |=> in_full_reg && event_reg
    ) else $error("write end did not set both flags"); // RL8

    a_strobe_seen: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (slave_on && !pe_eff[PIN_SELECT] && !pe_eff[PIN_WRITE])
        ##1 (slave_on && (pe_eff[PIN_SELECT] || pe_eff[PIN_WRITE]))
        |-> wr_end
    ) else $error("write end not detected on strobe rise"); // RL7

    a_read_drive: assert property (
        @(posedge aclk) disable iff (!aresetn)
        rd_start |=> port_d_oe == 8'hff && !out_full_reg
    ) else $error("read start did not drive port or clear full"); // RL9

    a_read_release: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (rd_end ##1 slave_on) |-> port_d_oe == 8'h00 && event_reg
    ) else $error("read end did not float port and flag"); // RL11

    a_write_in_read: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (sw_pd_write && rd_act) |=>
            !out_full_reg && port_d_out == $past(w_data_reg)
    ) else $error("write during read mishandled"); // RL10

    a_out_full_set: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (sw_pd_write && !rd_act) |=> out_full_reg
    ) else $error("output full not set by software write"); // RL14

    a_in_full_clear: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (sw_pd_read && !wr_end) |=> !in_full_reg
    ) else $error("software read did not clear input full"); // RL13

    a_overflow_set: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (wr_end && in_full_reg && !sw_pd_read) |=> in_ovf_reg
    ) else $error("overflow not flagged"); // RL13

    a_ctl_layout: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (ar_take && s_axi_araddr[7:0] == OFF_PE_CTL) |=> s_axi_rdata[7:4]
            == $past({in_full_reg, out_full_reg, in_ovf_reg, enable_reg})
    ) else $error("control view bits misplaced"); // RL2

    a_bvalid_hold: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid
    ) else $error("write response dropped early");

endmodule : pslv_top

//--- dv/pslv_ext_cpu.sv
`timescale 1ns/1ps
module pslv_ext_cpu (
    input  wire logic       aclk,
    input  wire logic [7:0] port_d_out,
    input  wire logic [7:0] port_d_oe,
    output logic      [7:0] port_d_in,
    output logic      [2:0] port_e_in
);
    logic       drv;
    logic [7:0] drv_val;
    logic [7:0] idle_val;

    initial begin
        drv = 1'b0;
        drv_val = 8'h00;
        idle_val = 8'h55;
        port_e_in = 3'h7;
    end

    // a released bus toggles every cycle so stale data never passes
    always @(posedge aclk) idle_val <= ~idle_val;

    assign port_d_in = (port_d_oe & port_d_out)
                     | (~port_d_oe & (drv ? drv_val : idle_val));

    task ext_write(input logic [7:0] d);
        @(posedge aclk);
        drv <= 1'b1;
        drv_val <= d;
        port_e_in <= 3'h1;
        repeat (6) @(posedge aclk);
        port_e_in <= 3'h7;
        // data held past the strobe rise, then released
        repeat (4) @(posedge aclk);
        drv <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask : ext_write

    task ext_read(output logic [7:0] d);
        @(posedge aclk);
        port_e_in <= 3'h2;
        repeat (12) @(posedge aclk);
        @(negedge aclk);
        d = port_d_in;
        @(posedge aclk);
        port_e_in <= 3'h7;
        repeat (6) @(posedge aclk);
    endtask : ext_read
endmodule : pslv_ext_cpu

//--- dv/pslv_tb.sv
`timescale 1ns/1ps
module tb;
    import pslv_pkg::*;
    localparam logic [31:0] ON  = (32'h1 << CTL_ENABLE) | 32'h7;
    localparam logic [31:0] INPUT_BUFFER_FULL = 32'h1 << CTL_IN_FULL;
    localparam logic [31:0] OUTPUT_BUFFER_FULL = 32'h1 << CTL_OUT_FULL;
    localparam logic [31:0] OVF = 32'h1 << CTL_IN_OVF;
    localparam logic [31:0] EVT = 32'h1 << FLAG_EVENT;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid;
    logic        rready, pwm, awready, wready, bvalid, arready;
    logic        rvalid, irq;
    logic [7:0]  awaddr, araddr, pd_out, pd_oe, pd_in;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, b_resp;
    logic [2:0]  pe_out, pe_oe, pe_in;
    int          err_total;
    int          comparisons;

    pslv_top i_pslv_top (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .port_d_in(pd_in),
        .port_d_out(pd_out), .port_d_oe(pd_oe),
        .port_e_in(pe_in), .port_e_out(pe_out), .port_e_oe(pe_oe),
        .pwm_multi_output(pwm), .irq(irq)
    );

    pslv_ext_cpu u_cpu (
        .aclk(aclk), .port_d_out(pd_out), .port_d_oe(pd_oe),
        .port_d_in(pd_in), .port_e_in(pe_in)
    );

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    task results;
        if (err_total == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic ha, hw, hb, done;
        done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(negedge aclk);
            ha = awvalid && awready;
            hw = wvalid && wready;
            hb = bready && bvalid;
            b_resp = bresp;
            @(posedge aclk);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
            if (hb) bready <= 1'b0;
            done = hb;
        end
    endtask : axi_wr

    task axi_rd(input logic [7:0] a, output logic [31:0] d,
                output logic [1:0] r);
        logic ha, hr, done;
        done = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(negedge aclk);
            ha = arvalid && arready;
            hr = rready && rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ha) arvalid <= 1'b0;
            if (hr) rready <= 1'b0;
            done = hr;
        end
    endtask : axi_rd

    task rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        chk(n, e, d);
        chk({n, " resp"}, {30'h0, RESP_OKAY}, {30'h0, r});
    endtask : rd_chk

    task chk_irq(input logic e);
        @(negedge aclk);
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask : chk_irq

    task t_reset;
        logic [31:0] d;
        logic [1:0]  r;
        rd_chk("pd dir", OFF_PD_DIR, {24'h0, RST_PD_DIR});
        rd_chk("pe ctl", OFF_PE_CTL, {29'h0, RST_PE_DIR});
        rd_chk("analog", OFF_ANALOG, {24'h0, RST_ANALOG});
        rd_chk("flags", OFF_FLAGS, 32'h0);
        rd_chk("latch", OFF_PD_LATCH, 32'h0);
        axi_rd(8'h2c, d, r);
        chk("unmapped resp", {30'h0, RESP_DECERR}, {30'h0, r});
        chk("unmapped data", 32'h0, d);
        axi_wr(8'h2c, 32'hff);
        chk("unmapped wr resp", {30'h0, RESP_DECERR}, {30'h0, b_resp});
        chk_irq(1'b0);
    endtask : t_reset

    task t_setup;
        axi_wr(OFF_ANALOG, 32'h1f);
        chk("wr resp", {30'h0, RESP_OKAY}, {30'h0, b_resp});
        axi_wr(OFF_ENABLES, EVT);
        axi_wr(OFF_PE_CTL, ON);
        rd_chk("ctl on", OFF_PE_CTL, ON);
        chk("pe oe", 32'h0, {29'h0, pe_oe});
    endtask : t_setup

    task t_ext_write;
        u_cpu.ext_write(8'ha5);
        rd_chk("flags", OFF_FLAGS, EVT);
        rd_chk("ctl ibf", OFF_PE_CTL, ON | INPUT_BUFFER_FULL);
        chk_irq(1'b1);
        rd_chk("pd data", OFF_PD_PINS, 32'ha5);
        rd_chk("ctl rd", OFF_PE_CTL, ON);
        axi_wr(OFF_FLAGS_CLR, EVT);
        chk_irq(1'b0);
    endtask : t_ext_write

    task t_overflow;
        u_cpu.ext_write(8'h11);
        u_cpu.ext_write(8'h22);
        rd_chk("ctl ovf", OFF_PE_CTL, ON | INPUT_BUFFER_FULL | OVF);
        rd_chk("pd last", OFF_PD_PINS, 32'h22);
        axi_wr(OFF_PE_CTL, ON);
        rd_chk("ctl clr", OFF_PE_CTL, ON);
        axi_wr(OFF_ENABLES, 32'h0);
        chk_irq(1'b0);
        axi_wr(OFF_ENABLES, EVT);
        chk_irq(1'b1);
        axi_wr(OFF_FLAGS_CLR, EVT);
        rd_chk("clr reg", OFF_FLAGS_CLR, 32'h0);
        chk_irq(1'b0);
    endtask : t_overflow

    task t_ext_read;
        logic [7:0] v;
        axi_wr(OFF_PD_PINS, 32'h3c);
        rd_chk("ctl obf", OFF_PE_CTL, ON | OUTPUT_BUFFER_FULL);
        u_cpu.ext_read(v);
        chk("ext data", 32'h3c, {24'h0, v});
        @(negedge aclk);
        chk("oe end", 32'h0, {24'h0, pd_oe});
        rd_chk("flags rd", OFF_FLAGS, EVT);
        rd_chk("ctl rd", OFF_PE_CTL, ON);
        axi_wr(OFF_FLAGS_CLR, EVT);
    endtask : t_ext_read

    task t_read_update;
        logic [7:0] v;
        fork
            u_cpu.ext_read(v);
            begin
                repeat (5) @(posedge aclk);
                axi_wr(OFF_PD_PINS, 32'h5a);
                @(negedge aclk);
                chk("oe read", 32'hff, {24'h0, pd_oe});
            end
        join
        chk("new data", 32'h5a, {24'h0, v});
        rd_chk("ctl no obf", OFF_PE_CTL, ON);
        axi_wr(OFF_FLAGS_CLR, EVT);
    endtask : t_read_update

    task t_blocked;
        @(posedge aclk);
        pwm <= 1'b1;
        u_cpu.ext_write(8'h77);
        rd_chk("ctl pwm", OFF_PE_CTL, ON);
        rd_chk("flags pwm", OFF_FLAGS, 32'h0);
        @(posedge aclk);
        pwm <= 1'b0;
        axi_wr(OFF_PE_CTL, 32'h7);
        u_cpu.ext_write(8'h66);
        rd_chk("flags off", OFF_FLAGS, 32'h0);
        axi_wr(OFF_PD_DIR, 32'h0f);
        @(negedge aclk);
        chk("oe gpio", 32'hf0, {24'h0, pd_oe});
        axi_wr(OFF_PE_LATCH, 32'h5);
        axi_wr(OFF_PE_CTL, 32'h2);
        @(negedge aclk);
        chk("pe out", 32'h5, {29'h0, pe_out});
        chk("pe oe gpio", 32'h5, {29'h0, pe_oe});
    endtask : t_blocked

    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, pwm} = 6'h0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hf;
        err_total = 0;
        comparisons = 0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_setup();
        t_ext_write();
        t_overflow();
        t_ext_read();
        t_read_update();
        t_blocked();
        results();
    end

    initial begin
        repeat (5000) @(posedge aclk);
        err_total++;
        results();
    end
endmodule : tb
